// [bench/pcd_diag_chk.sv]
// checker for the cable diagnostic top, watching its ports only
// assumes binding onto pcd_diag_top with its parameters handed on
`timescale 1ns/100ps
module pcd_diag_chk #(
    parameter DW       = 5,
    parameter ECHO_CYC = 8,
    parameter SRST_CYC = 8
) (
    input wire          mclk_i,
    input wire          nrst_i,
    input wire          crossover_state_select_i,
    input wire          tdr_enable_i,
    input wire          near_loop_enable_i,
    input wire          collision_test_enable_i,
    input wire          fibre_mode_i,
    input wire          fibre_los_mode_i,
    input wire          fibre_quality_i,
    input wire          link_up_i,
    input wire          link_100_i,
    input wire [DW-1:0] tx_scr_i,
    input wire          tx_en_i,
    input wire          pulse_tx_pair_o,
    input wire          pulse_rx_pair_o,
    input wire          link_drop_o,
    input wire          tdr_done_o,
    input wire          tdr_length_valid_o,
    input wire          matched_length_valid_o,
    input wire          signal_status_o,
    input wire          phy_soft_reset_o,
    input wire [DW-1:0] rx_sym_o,
    input wire          line_tx_power_o,
    input wire          mlt3_enable_o,
    input wire          col_o
);
    // ************************************************
    // assertions, one clock domain
    // ************************************************
    localparam int DONE_MAX = ECHO_CYC + 6;
    localparam int SRST_MAX = SRST_CYC + 3;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    wire pulse = pulse_tx_pair_o | pulse_rx_pair_o;

    a_loop_tx_off:
        assert property (near_loop_enable_i |=> !line_tx_power_o)
        else $error("line driver powered in loopback");
    a_loop_col_quiet:
        assert property (near_loop_enable_i && !collision_test_enable_i
            |=> !col_o) else $error("collision active in loopback");
    a_loop_col_test:
        assert property (near_loop_enable_i && collision_test_enable_i
            |=> col_o == $past(tx_en_i)) else $error("collision test lost");
    a_loop_data_back:
        assert property (near_loop_enable_i |=> rx_sym_o == $past(tx_scr_i))
        else $error("loopback data not returned");
    a_fibre_no_mlt3:
        assert property (fibre_mode_i |=> !mlt3_enable_o)
        else $error("line coder used in fibre mode");
    a_pulse_pair_sel:
        assert property (pulse |-> pulse_tx_pair_o != pulse_rx_pair_o &&
            pulse_rx_pair_o == $past(crossover_state_select_i) ##1 !pulse)
        else $error("test pulse on wrong pair");
    a_drop_in_test:
        assert property (pulse |-> link_drop_o)
        else $error("link kept during test");
    a_done_bound:
        assert property (pulse |-> ##[0:DONE_MAX] (tdr_done_o || !tdr_enable_i))
        else $error("test never finished");
    a_fibre_no_valid:
        assert property (fibre_mode_i |=> !tdr_length_valid_o)
        else $error("length valid in fibre mode");
    a_match_link:
        assert property (matched_length_valid_o |->
            $past(link_up_i) && $past(link_100_i))
        else $error("matched length valid without link");
    a_fx_status:
        assert property (fibre_mode_i |=> signal_status_o ==
            ($past(fibre_quality_i) ^ $past(fibre_los_mode_i)))
        else $error("fibre status not from quality input");
    a_srst_self:
        assert property (phy_soft_reset_o |-> ##[1:SRST_MAX] !phy_soft_reset_o)
        else $error("soft reset bit stuck");

    // main scenarios reached
    c_pulse_rx: cover property (pulse_rx_pair_o);
    c_col_test: cover property (near_loop_enable_i && col_o);
    c_match: cover property (matched_length_valid_o);
    c_srst: cover property ($fell(phy_soft_reset_o));
endmodule
bind pcd_diag_top pcd_diag_chk #(.DW(DW), .ECHO_CYC(ECHO_CYC),
    .SRST_CYC(SRST_CYC)) i_chk (.*);

// [bench/pcd_line_model.sv]
// far side model: cable reflection and line receive traffic
// assumes test pulses from the top and one clock, no reset
`timescale 1ns/100ps
module pcd_line_model (
    input  wire       mclk_i,
    input  wire       pulse_i,
    input  wire [7:0] delay_i,
    input  wire       open_i,
    output reg        echo_o = 1'b0,
    output reg  [4:0] line_rx_o = 5'h00,
    output reg        line_col_o = 1'b0
);
    reg [7:0] wait_cnt = 8'h00;
    // echo comes delay_i cycles after a pulse on either pair
    // delay_i stands for fault distance over the fault constant
    always @(posedge mclk_i) begin
        echo_o <= 1'b0;
        if (pulse_i) begin
            wait_cnt <= delay_i;
        end else if (wait_cnt != 8'h00) begin
            wait_cnt <= wait_cnt - 8'h01;
            // a terminated cable never reflects
            echo_o <= (wait_cnt == 8'h01) && open_i;
        end
    end
    // line symbols change every cycle so stale data cannot match
    always @(posedge mclk_i) begin
        line_rx_o <= line_rx_o + 5'h07;
        line_col_o <= ~line_col_o;
    end
endmodule

// [bench/tb_top.sv]
// bench for the cable diagnostic top with a line side model
// assumes the checker is bound from its own file
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    mismatches++; $display("FAIL %s exp %0h got %0h", n, e, g); end end
module tb_top;
    logic       mclk_i = 1'b0;
    logic       nrst_i, tdr_enable_i, crossover_state_select_i;
    logic       auto_crossover_i, link_up_i, link_100_i, near_loop_enable_i;
    logic       collision_test_enable_i, fibre_mode_i, fibre_los_mode_i;
    logic       fibre_quality_i, copper_signal_i, phy_soft_reset_i, tx_en_i;
    logic [3:0] matched_length_code_i;
    logic [4:0] tx_coded_i, tx_scr_i, v;
    logic [7:0] echo_delay, l1, l2;
    logic       cable_open;
    wire        echo_seen_i, line_col_i, pulse_tx_pair_o, pulse_rx_pair_o;
    wire        link_drop_o, tdr_done_o, tdr_length_valid_o, signal_status_o;
    wire        matched_length_valid_o, phy_soft_reset_o, core_reset_o;
    wire        line_tx_power_o, mlt3_enable_o, col_o;
    wire [4:0]  line_rx_i, rx_sym_o, line_tx_o;
    wire [7:0]  tdr_channel_length_o;
    wire [6:0]  matched_length_metres_o;
    integer     mismatches = 0;
    integer     comparisons = 0;
    integer     cyc = 0;
    integer     i;
    logic [6:0] tab [0:15] = '{7'h00, 7'h00, 7'h00, 7'h00, 7'h06, 7'h11,
        7'h1B, 7'h26, 7'h31, 7'h3B, 7'h46, 7'h51, 7'h5B, 7'h66, 7'h71, 7'h7B};

    always #5 mclk_i = ~mclk_i;
    pcd_diag_top #(.DW(5), .ECHO_CYC(40), .SRST_CYC(8)) i_dut (.*);
    pcd_line_model i_line (.mclk_i(mclk_i), .pulse_i(pulse_tx_pair_o |
        pulse_rx_pair_o), .delay_i(echo_delay), .open_i(cable_open),
        .echo_o(echo_seen_i), .line_rx_o(line_rx_i), .line_col_o(line_col_i));

    // ************************************************
    // tasks
    // ************************************************
    task step(input integer n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    // one test: pulse on the pair chosen by xo, wait for done, then read the length
    task tdr_run(input logic xo, input logic [7:0] d, input logic op,
                 output logic [7:0] len);
        crossover_state_select_i = xo;
        echo_delay = d;
        cable_open = op;
        tdr_enable_i = 1'b1;
        for (i = 0; i < 6 && (pulse_tx_pair_o | pulse_rx_pair_o) !== 1'b1;
             i++) step(1);
        `CHK("pulse_tx", !xo, pulse_tx_pair_o)
        `CHK("pulse_rx", xo, pulse_rx_pair_o)
        `CHK("link_drop", 1'b1, link_drop_o)
        for (i = 0; i < 60 && tdr_done_o !== 1'b1; i++) step(1);
        `CHK("tdr_done", 1'b1, tdr_done_o)
        `CHK("tdr_valid", op, tdr_length_valid_o)
        len = tdr_channel_length_o;
        tdr_enable_i = 1'b0;
        step(3);
    endtask
    // each pair in turn, then a matched cable
    task t_tdr;
        tdr_run(1'b0, 8'h03, 1'b1, l1);
        tdr_run(1'b1, 8'h0A, 1'b1, l2);
        `CHK("tdr_len_step", 8'h07, l2 - l1)
        tdr_run(1'b0, 8'h03, 1'b0, l1);
        auto_crossover_i = 1'b1;
        tdr_enable_i = 1'b1;
        for (i = 0; i < 12; i++) begin
            fibre_mode_i = (i >= 6);
            auto_crossover_i = (i < 6);
            step(1);
            `CHK("refused", 1'b0, pulse_tx_pair_o | link_drop_o)
        end
        tdr_enable_i = 1'b0;
        fibre_mode_i = 1'b0;
        step(2);
    endtask
    task t_match;
        link_up_i = 1'b1;
        link_100_i = 1'b1;
        for (int c = 0; c < 16; c++) begin
            matched_length_code_i = c[3:0];
            step(2);
            `CHK("metres", tab[c], matched_length_metres_o)
            `CHK("match_valid", 1'b1, matched_length_valid_o)
        end
        link_100_i = 1'b0;
        step(2);
        `CHK("match_valid_10", 1'b0, matched_length_valid_o)
    endtask
    task t_loop;
        near_loop_enable_i = 1'b1;
        tx_en_i = 1'b1;
        tx_scr_i = 5'h15;
        tx_coded_i = 5'h0A;
        step(2);
        `CHK("loop_rx", 5'h15, rx_sym_o)
        `CHK("loop_power", 1'b0, line_tx_power_o)
        `CHK("loop_col", 1'b0, col_o)
        collision_test_enable_i = 1'b1;
        step(2);
        `CHK("loop_col_test", 1'b1, col_o)
        near_loop_enable_i = 1'b0;
        step(2);
        `CHK("conn_power", 1'b1, line_tx_power_o)
        v = line_rx_i;
        step(1);
        `CHK("conn_rx", v, rx_sym_o)
        `CHK("copper_tx", 5'h15, line_tx_o)
        `CHK("copper_mlt3", 1'b1, mlt3_enable_o)
    endtask
    // fibre quality supplied by the transceiver side
    task fx(input logic fm, los, q, cu, ex);
        fibre_mode_i = fm;
        fibre_los_mode_i = los;
        fibre_quality_i = q;
        copper_signal_i = cu;
        step(2);
        `CHK("status", ex, signal_status_o)
    endtask
    task t_fibre_srst;
        fx(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
        `CHK("fx_mlt3", 1'b0, mlt3_enable_o)
        `CHK("fx_line_tx", 5'h0A, line_tx_o)
        fx(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
        fx(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        fx(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
        phy_soft_reset_i = 1'b1;
        step(1);
        phy_soft_reset_i = 1'b0;
        `CHK("srst_bit", 1'b1, phy_soft_reset_o)
        `CHK("core_reset", 1'b1, core_reset_o)
        step(12);
        `CHK("srst_clear", 1'b0, phy_soft_reset_o)
        `CHK("core_reset_clr", 1'b0, core_reset_o)
        `CHK("srst_done_clr", 1'b0, tdr_done_o)
    endtask
    task conclude;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ************************************************
    // sequence and hang guard
    // ************************************************
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            mismatches++;
            conclude;
        end
    end
    initial begin
        {nrst_i, tdr_enable_i, crossover_state_select_i, auto_crossover_i,
         link_up_i, link_100_i, near_loop_enable_i, collision_test_enable_i,
         fibre_mode_i, fibre_los_mode_i, fibre_quality_i, copper_signal_i,
         phy_soft_reset_i, tx_en_i, cable_open} = 15'h0000;
        {matched_length_code_i, tx_coded_i, tx_scr_i, echo_delay} = 22'h0;
        step(3);
        nrst_i = 1'b1;
        t_tdr;
        t_match;
        t_loop;
        t_fibre_srst;
        conclude;
    end
endmodule

// [core/pcd_diag_top.v]
// cable diagnostic, loopback and fibre path control top
// assumes analog front end gives an echo strobe
// assumes tdr_enable_i held high for the whole test
// soft reset clears diagnostics, not the symbol path
// counters saturate, so a stuck front end cannot wrap
`timescale 1ns/100ps
`include "pcd_map.vh"
module pcd_diag_top #(
    parameter DW        = 5,
    parameter ECHO_CYC  = `PCD_ECHO_CYC,
    parameter SRST_CYC  = `PCD_SRST_CYC
) (
    // clock, reset and TDR request
    input  wire                   mclk_i,
    input  wire                   nrst_i,
    input  wire                   tdr_enable_i,
    input  wire                   crossover_state_select_i,
    input  wire                   auto_crossover_i,
    input  wire                   echo_seen_i,
    // link state and matched length code
    input  wire                   link_up_i,
    input  wire                   link_100_i,
    input  wire [`PCD_CODE_W-1:0] matched_length_code_i,
    // loopback, fibre and soft reset controls
    input  wire                   near_loop_enable_i,
    input  wire                   collision_test_enable_i,
    input  wire                   fibre_mode_i,
    input  wire                   fibre_los_mode_i,
    input  wire                   fibre_quality_i,
    input  wire                   copper_signal_i,
    input  wire                   phy_soft_reset_i,
    // symbol path from the coding sublayers and the line
    input  wire [DW-1:0]          tx_coded_i,
    input  wire [DW-1:0]          tx_scr_i,
    input  wire [DW-1:0]          line_rx_i,
    input  wire                   tx_en_i,
    input  wire                   line_col_i,
    // TDR pulse steering and results
    output reg                    pulse_tx_pair_o,
    output reg                    pulse_rx_pair_o,
    output reg                    link_drop_o,
    output reg  [`PCD_LEN_W-1:0]  tdr_channel_length_o,
    output reg                    tdr_done_o,
    output reg                    tdr_length_valid_o,
    // matched length, receive status and soft reset
    output reg  [`PCD_MET_W-1:0]  matched_length_metres_o,
    output reg                    matched_length_valid_o,
    output reg                    signal_status_o,
    output reg                    phy_soft_reset_o,
    output reg                    core_reset_o,
    // steered symbol path
    output wire [DW-1:0]          rx_sym_o,
    output wire [DW-1:0]          line_tx_o,
    output wire                   line_tx_power_o,
    output wire                   mlt3_enable_o,
    output wire                   col_o
);
    // ****************************************************
    // state encodings, one hot
    // ****************************************************
    // DONE keeps the result until the enable drops
    localparam [3:0] ST_IDLE  = 4'h1;
    localparam [3:0] ST_PULSE = 4'h2;
    localparam [3:0] ST_WAIT  = 4'h4;
    localparam [3:0] ST_DONE  = 4'h8;

    reg  [3:0]            state;
    reg  [3:0]            next_state;
    reg  [`PCD_CNT_W-1:0] echo_cnt;
    reg  [`PCD_CNT_W-1:0] srst_cnt;
    reg                   straight;
    reg                   diag_ok;
    wire [`PCD_MET_W-1:0] lut_metres;
    // sequencer events and status sources
    wire                  start_pulse;
    wire                  test_finish;
    wire                  link_ok;
    wire                  fibre_status;
    wire                  srst_start;
    wire                  srst_end;

    // saturating increment used by both counters
    function [`PCD_CNT_W-1:0] sat_inc;
        input [`PCD_CNT_W-1:0] v;
        begin
            if (&v)
                sat_inc = v;
            else
                sat_inc = v + `PCD_CNT_ONE;
        end
    endfunction

    // ****************************************************
    // TDR sequencer
    // ****************************************************
    // next state selection
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (tdr_enable_i && diag_ok)
                    next_state = ST_PULSE;
            ST_PULSE:
                next_state = ST_WAIT;
            ST_WAIT:
                if (!tdr_enable_i)
                    next_state = ST_IDLE;
                else if (echo_seen_i ||
                         echo_cnt >= ECHO_CYC[`PCD_CNT_W-1:0])
                    next_state = ST_DONE;
            ST_DONE:
                if (!tdr_enable_i)
                    next_state = ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    // diagnostics allowed only on copper, fixed crossover
    always @* begin
        diag_ok  = ~fibre_mode_i & ~auto_crossover_i;
        // fixed crossover state names the pair under test
        straight = ~crossover_state_select_i;
    end

    // ****************************************************
    // sequencer events
    // ****************************************************
    // test start, and the edge that ends the wait for an echo
    assign start_pulse = (next_state == ST_PULSE);
    assign test_finish = (state == ST_WAIT) & (next_state == ST_DONE);

    // state register, cleared by either reset
    always @(posedge mclk_i) begin
        if (!nrst_i || core_reset_o) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // echo interval counter, restarted by each pulse
    always @(posedge mclk_i) begin
        if (!nrst_i || core_reset_o) begin
            echo_cnt <= `PCD_CNT_ZERO;
        end else if (start_pulse) begin
            echo_cnt <= `PCD_CNT_ZERO;
        end else if (state == ST_WAIT) begin
            echo_cnt <= sat_inc(echo_cnt);
        end
    end

    // ****************************************************
    // pulse steering and link drop
    // ****************************************************
    // registered from next state, so they align with PULSE
    always @(posedge mclk_i) begin
        if (!nrst_i || core_reset_o) begin
            pulse_tx_pair_o <= 1'b0;
            pulse_rx_pair_o <= 1'b0;
            link_drop_o     <= 1'b0;
        end else begin
            // link held down from pulse to test end
            link_drop_o <= (next_state != ST_IDLE);
            // one cycle pulse on the chosen pair
            pulse_tx_pair_o <= start_pulse & straight;
            pulse_rx_pair_o <= start_pulse & ~straight;
        end
    end

    // ****************************************************
    // TDR results
    // ****************************************************
    // result capture; a new test clears the done and valid flags
    always @(posedge mclk_i) begin
        if (!nrst_i || core_reset_o) begin
            tdr_channel_length_o <= `PCD_LEN_ZERO;
            tdr_done_o           <= 1'b0;
            tdr_length_valid_o   <= 1'b0;
        end else begin
            if (start_pulse) begin
                tdr_done_o         <= 1'b0;
                tdr_length_valid_o <= 1'b0;
            end
            if (test_finish) begin
                tdr_done_o <= 1'b1;
                // no echo means a matched cable: result invalid
                tdr_length_valid_o <= echo_seen_i;
                // intervals beyond the field saturate it
                if (echo_cnt[`PCD_CNT_W-1:`PCD_LEN_W] != `PCD_LEN_ZERO)
                    tdr_channel_length_o <= `PCD_LEN_MAX;
                else
                    tdr_channel_length_o <=
                        echo_cnt[`PCD_LEN_W-1:0];
            end
            // fibre mode never leaves a result marked valid
            if (fibre_mode_i)
                tdr_length_valid_o <= 1'b0;
        end
    end

    // ****************************************************
    // matched cable length
    // ****************************************************
    pcd_len_lut u_lut (
        .code_i   (matched_length_code_i),
        .metres_o (lut_metres)
    );

    // a length estimate needs a 100M copper link
    assign link_ok = link_up_i & link_100_i & ~fibre_mode_i;

    // metres follow the code one cycle later
    always @(posedge mclk_i) begin
        if (!nrst_i || core_reset_o) begin
            matched_length_metres_o <= `PCD_M_ZERO;
        end else begin
            matched_length_metres_o <= lut_metres;
        end
    end

    // valid flag tracks the link one cycle later
    always @(posedge mclk_i) begin
        if (!nrst_i || core_reset_o) begin
            matched_length_valid_o <= 1'b0;
        end else begin
            matched_length_valid_o <= link_ok;
        end
    end

    // ****************************************************
    // receive signal status
    // ****************************************************
    // loss of signal is inverted, signal detect used as is
    assign fibre_status = fibre_los_mode_i ? ~fibre_quality_i
                                           : fibre_quality_i;

    // status register takes the fibre or copper source
    always @(posedge mclk_i) begin
        if (!nrst_i) begin
            signal_status_o <= 1'b0;
        end else if (fibre_mode_i) begin
            signal_status_o <= fibre_status;
        end else begin
            signal_status_o <= copper_signal_i;
        end
    end

    // ****************************************************
    // soft reset, self clearing
    // ****************************************************
    // a request is taken only while no soft reset runs
    assign srst_start = phy_soft_reset_i & ~phy_soft_reset_o;
    // the hold time ends on the last counted cycle
    assign srst_end   = phy_soft_reset_o &
                        (srst_cnt >= SRST_CYC[`PCD_CNT_W-1:0] - `PCD_CNT_ONE);

    // straps are not resampled; only block state is cleared
    always @(posedge mclk_i) begin
        if (!nrst_i) begin
            phy_soft_reset_o <= 1'b0;
            core_reset_o     <= 1'b0;
        end else if (srst_start) begin
            phy_soft_reset_o <= 1'b1;
            core_reset_o     <= 1'b1;
        end else if (srst_end) begin
            phy_soft_reset_o <= 1'b0;
            core_reset_o     <= 1'b0;
        end
    end

    // hold time counter runs only while the bit is set
    always @(posedge mclk_i) begin
        if (!nrst_i || srst_start) begin
            srst_cnt <= `PCD_CNT_ZERO;
        end else if (phy_soft_reset_o) begin
            srst_cnt <= sat_inc(srst_cnt);
        end
    end

    // ****************************************************
    // data path steering
    // ****************************************************
    // connector loopback is the normal path at either speed
    pcd_path_mux #(
        .DW (DW)
    ) u_path (
        .mclk_i                  (mclk_i),
        .nrst_i                  (nrst_i),
        .near_loop_enable_i      (near_loop_enable_i),
        .collision_test_enable_i (collision_test_enable_i),
        .fibre_mode_i            (fibre_mode_i),
        .tx_coded_i              (tx_coded_i),
        .tx_scr_i                (tx_scr_i),
        .line_rx_i               (line_rx_i),
        .tx_en_i                 (tx_en_i),
        .line_col_i              (line_col_i),
        .rx_sym_o                (rx_sym_o),
        .line_tx_o               (line_tx_o),
        .line_tx_power_o         (line_tx_power_o),
        .mlt3_enable_o           (mlt3_enable_o),
        .col_o                   (col_o)
    );
endmodule

// [core/pcd_len_lut.v]
// matched cable length code to metres lookup
// assumes a registered code at its input
`timescale 1ns/100ps
`include "pcd_map.vh"
module pcd_len_lut (
    input  wire [`PCD_CODE_W-1:0] code_i,
    output reg  [`PCD_MET_W-1:0]  metres_o
);
    // codes 0 to 3 read as zero metres
    always @* begin
        case (code_i)
            4'h4:    metres_o = `PCD_M_C4;
            4'h5:    metres_o = `PCD_M_C5;
            4'h6:    metres_o = `PCD_M_C6;
            4'h7:    metres_o = `PCD_M_C7;
            4'h8:    metres_o = `PCD_M_C8;
            4'h9:    metres_o = `PCD_M_C9;
            4'hA:    metres_o = `PCD_M_C10;
            4'hB:    metres_o = `PCD_M_C11;
            4'hC:    metres_o = `PCD_M_C12;
            4'hD:    metres_o = `PCD_M_C13;
            4'hE:    metres_o = `PCD_M_C14;
            4'hF:    metres_o = `PCD_M_C15;
            default: metres_o = `PCD_M_ZERO;
        endcase
    end
endmodule

// [core/pcd_map.vh]
// constants for the cable diagnostic and loopback control block
// assumes inclusion by the core files of this block only
`ifndef PCD_MAP_VH
`define PCD_MAP_VH

// ****************************************************
// widths and timing
// ****************************************************
`define PCD_LEN_W        8
`define PCD_CODE_W       4
`define PCD_MET_W        7
`define PCD_CNT_W        16
`define PCD_LEN_ZERO     8'h00
`define PCD_LEN_MAX      8'hFF
`define PCD_CNT_ZERO     16'h0000
`define PCD_CNT_ONE      16'h0001
// echo watch window, in ns, and soft reset length, in ns
`define PCD_ECHO_NS      2560
`define PCD_SRST_NS      1000
`define PCD_CLK_NS       10
`define PCD_ECHO_CYC     (`PCD_ECHO_NS / `PCD_CLK_NS)
`define PCD_SRST_CYC     (`PCD_SRST_NS / `PCD_CLK_NS)

// ****************************************************
// matched length table, metres per code
// ****************************************************
`define PCD_M_C4         7'h06
`define PCD_M_C5         7'h11
`define PCD_M_C6         7'h1B
`define PCD_M_C7         7'h26
`define PCD_M_C8         7'h31
`define PCD_M_C9         7'h3B
`define PCD_M_C10        7'h46
`define PCD_M_C11        7'h51
`define PCD_M_C12        7'h5B
`define PCD_M_C13        7'h66
`define PCD_M_C14        7'h71
`define PCD_M_C15        7'h7B
`define PCD_M_ZERO       7'h00

`endif

// [core/pcd_path_mux.v]
// digital data path steering for loopback and fibre mode
// assumes symbols and controls synchronous to the core clock
`timescale 1ns/100ps
module pcd_path_mux #(
    parameter DW = 5
) (
    input  wire          mclk_i,
    input  wire          nrst_i,
    input  wire          near_loop_enable_i,
    input  wire          collision_test_enable_i,
    input  wire          fibre_mode_i,
    input  wire [DW-1:0] tx_coded_i,
    input  wire [DW-1:0] tx_scr_i,
    input  wire [DW-1:0] line_rx_i,
    input  wire          tx_en_i,
    input  wire          line_col_i,
    output reg  [DW-1:0] rx_sym_o,
    output reg  [DW-1:0] line_tx_o,
    output reg           line_tx_power_o,
    output reg           mlt3_enable_o,
    output reg           col_o
);
    // registered steering of transmit and receive symbols
    always @(posedge mclk_i) begin
        if (!nrst_i) begin
            rx_sym_o        <= {DW{1'b0}};
            line_tx_o       <= {DW{1'b0}};
            line_tx_power_o <= 1'b0;
            mlt3_enable_o   <= 1'b0;
            col_o           <= 1'b0;
        end else begin
            // loop taken after the full coded path
            rx_sym_o <= near_loop_enable_i ? tx_scr_i
                                           : line_rx_i;
            // fibre sends unscrambled symbols, no three level coder
            line_tx_o     <= fibre_mode_i ? tx_coded_i
                                          : tx_scr_i;
            mlt3_enable_o <= ~fibre_mode_i;
            // drivers stay off in loopback whatever tx_en says
            line_tx_power_o <= tx_en_i & ~near_loop_enable_i;
            // collision quiet in loopback unless collision test
            if (near_loop_enable_i)
                col_o <= collision_test_enable_i & tx_en_i;
            else
                col_o <= line_col_i;
        end
    end
endmodule
